// ### src/gplc_top.sv
// pin and i/o level control block behind an ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
module gplc_top
	import gplc_pkg::*;
(
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire logic [NUM_PINS-1:0]  pin_in,
	input  wire logic                 detected_3v3,
	input  wire logic [NUM_RX-1:0]    rx_enabled,
	input  wire gplc_rx_stat_t [3:0]  rx_stat,
	input  wire gplc_tx_stat_t [1:0]  tx_stat,
	input  wire logic                 frame_sync,
	output var gplc_io_level_t        io_level,
	output logic [NUM_PINS-1:0]       pin_input_enable,
	output logic                      pin0_out,
	output logic                      pin0_oe
);
	import gplc_pkg::*;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0]          io_level_control;
	logic [7:0]          pin_input_enables;
	logic [7:0]          pin0_output_control;
	logic [NUM_PINS:0]   synced;
	logic [NUM_PINS-1:0] pin_level_bits;
	logic                detected_sync;
	logic                next_pin0_data;
	logic                wr_pend;
	logic [ADDR_W-1:0]   wr_idx;
	logic [ADDR_W-1:0]   rd_idx;
	logic                rd_take;
	logic                wr_take;
	logic [7:0]          io_read;

	// ----------------------------------------------------------------
	// pin and supply-detect synchronisation
	// ----------------------------------------------------------------
	gplc_sync #(
		.W (NUM_PINS + 1)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       ({detected_3v3, pin_in}),
		.q       (synced)
	);

	// input-disabled pins read back low
	assign pin_level_bits = synced[NUM_PINS-1:0] & pin_input_enables;
	assign detected_sync  = synced[NUM_PINS];

	// ----------------------------------------------------------------
	// bus address phase decode
	// ----------------------------------------------------------------
	// zero-wait slave: a write lands one cycle after its address phase
	assign rd_take = hsel && hready && !hwrite && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign wr_take = hsel && hready && hwrite && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign rd_idx  = haddr[ADDR_W-1+WORD_SHIFT:WORD_SHIFT];

	// write address latch for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_idx  <= '0;
		end else begin
			wr_pend <= wr_take;
			wr_idx  <= rd_idx;
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	// level control: low nibble never stored, so it always reads zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			io_level_control <= RST_IO_LEVEL_CONTROL & 8'hF0;
		end else if (wr_pend && wr_idx == IDX_IO_LEVEL_CONTROL) begin
			io_level_control <= {hwdata[IO_SEL_BIT:IO_LVL_LO], 4'h0};
		end
	end

	// per-pin input enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_input_enables <= RST_PIN_INPUT_ENABLES;
		end else if (wr_pend && wr_idx == IDX_PIN_INPUT_ENABLES) begin
			pin_input_enables <= hwdata[7:0];
		end
	end

	// pin 0 output control
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin0_output_control <= RST_PIN0_OUTPUT_CONTROL;
		end else if (wr_pend && wr_idx == IDX_PIN0_OUTPUT_CONTROL) begin
			pin0_output_control <= hwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// active i/o level
	// ----------------------------------------------------------------
	// detected level is used unless the override is set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			io_level <= '0;
		end else if (io_level_control[IO_OVR_BIT]) begin
			io_level.high_voltage_select <= io_level_control[IO_SEL_BIT];
			io_level.supply_level        <= io_level_control[IO_LVL_HI:IO_LVL_LO];
		end else begin
			io_level.high_voltage_select <= detected_sync;
			io_level.supply_level        <= detected_sync ? LVL_3V3 : LVL_1V8;
		end
	end

	// read view of level control: detected level shown when override clear
	always_comb begin
		io_read = io_level_control;
		if (!io_level_control[IO_OVR_BIT]) begin
			io_read[IO_SEL_BIT]           = detected_sync;
			io_read[IO_LVL_HI:IO_LVL_LO]  = detected_sync ? LVL_3V3 : LVL_1V8;
		end
	end

	// ----------------------------------------------------------------
	// read data and response
	// ----------------------------------------------------------------
	// unmapped addresses read zero and answer okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (rd_take) begin
			case (rd_idx)
				IDX_IO_LEVEL_CONTROL:    hrdata <= {24'h000000, io_read};
				IDX_PIN_LEVEL_SNAPSHOT:  hrdata <= {24'h000000, pin_level_bits};
				IDX_PIN_INPUT_ENABLES:   hrdata <= {24'h000000, pin_input_enables};
				IDX_PIN0_OUTPUT_CONTROL: hrdata <= {24'h000000, pin0_output_control};
				default:                 hrdata <= '0;
			endcase
		end
	end

	// never stalls, never errors
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end
	end

	// ----------------------------------------------------------------
	// pin 0 output
	// ----------------------------------------------------------------
	gplc_pin0_mux u_mux (
		.src         (pin0_output_control[P0_SRC_HI:P0_SRC_LO]),
		.sel         (pin0_output_control[P0_SEL_HI:P0_SEL_LO]),
		.drive_value (pin0_output_control[P0_VAL_BIT]),
		.rx_enabled  (rx_enabled),
		.rx_stat     (rx_stat),
		.tx_stat     (tx_stat),
		.frame_sync  (frame_sync),
		.data        (next_pin0_data)
	);

	// driver forced off and data parked low while disabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin0_out <= 1'b0;
			pin0_oe  <= 1'b0;
		end else begin
			pin0_oe  <= pin0_output_control[P0_EN_BIT];
			pin0_out <= pin0_output_control[P0_EN_BIT] & next_pin0_data;
		end
	end

	// input enables leave on a register for the pad ring
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_input_enable <= RST_PIN_INPUT_ENABLES;
		end else begin
			pin_input_enable <= pin_input_enables;
		end
	end
endmodule : gplc_top
`default_nettype wire

// ### src/gplc_pkg.sv
// package with register map, field layout and carriers for the pin block
package gplc_pkg;

	// ----------------------------------------------------------------
	// register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0]  IDX_IO_LEVEL_CONTROL    = 8'h0D;
	localparam logic [7:0]  IDX_PIN_LEVEL_SNAPSHOT  = 8'h0E;
	localparam logic [7:0]  IDX_PIN_INPUT_ENABLES   = 8'h0F;
	localparam logic [7:0]  IDX_PIN0_OUTPUT_CONTROL = 8'h10;
	localparam int          ADDR_W                  = 8;
	localparam int          WORD_SHIFT              = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_IO_LEVEL_CONTROL    = 8'h09;
	localparam logic [7:0]  RST_PIN_INPUT_ENABLES   = 8'hFF;
	localparam logic [7:0]  RST_PIN0_OUTPUT_CONTROL = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int          IO_SEL_BIT   = 7;
	localparam int          IO_OVR_BIT   = 6;
	localparam int          IO_LVL_HI    = 5;
	localparam int          IO_LVL_LO    = 4;
	localparam int          IO_RSV_HI    = 3;
	localparam int          IO_RSV_LO    = 0;
	localparam int          P0_SEL_HI    = 7;
	localparam int          P0_SEL_LO    = 5;
	localparam int          P0_SRC_HI    = 4;
	localparam int          P0_SRC_LO    = 2;
	localparam int          P0_VAL_BIT   = 1;
	localparam int          P0_EN_BIT    = 0;
	localparam int          NUM_PINS     = 8;
	localparam int          NUM_RX       = 4;

	// supply level codes
	localparam logic [1:0]  LVL_1V8      = 2'h0;
	localparam logic [1:0]  LVL_3V3      = 2'h3;

	// source codes
	localparam logic [2:0]  SRC_DEV      = 3'h4;
	localparam logic [2:0]  SRC_TX0      = 3'h6;
	localparam logic [2:0]  SRC_TX1      = 3'h7;

	// ahb codes
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
	localparam logic        HRESP_OKAY    = 1'b0;

	// per receive port indications
	typedef struct packed {
		logic [3:0] remote_pin;
		logic       lock;
		logic       pass;
		logic       frame_valid;
		logic       line_valid;
	} gplc_rx_stat_t;

	// per video transmit port indications
	typedef struct packed {
		logic       pass_and;
		logic       pass_or;
		logic       frame_valid;
		logic       line_valid;
		logic       synced;
		logic       irq;
	} gplc_tx_stat_t;

	// active i/o level controls
	typedef struct packed {
		logic       high_voltage_select;
		logic [1:0] supply_level;
	} gplc_io_level_t;

	// pin 0 output driver controls
	typedef struct packed {
		logic       drive;
		logic       drive_enable;
	} gplc_pin0_drive_t;

endpackage : gplc_pkg

// ### src/gplc_sync.sv
// two-stage synchroniser for the eight pin levels and the detected supply
`timescale 1ns/100ps
`default_nettype none
module gplc_sync #(
	parameter int W = 9
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] stage1;

	// ----------------------------------------------------------------
	// double flop; first stage feeds only the second
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage1 <= '0;
			q      <= '0;
		end else begin
			stage1 <= d;
			q      <= stage1;
		end
	end
endmodule : gplc_sync
`default_nettype wire

// ### src/gplc_pin0_mux.sv
// output source and selector decode for pin 0
`timescale 1ns/100ps
`default_nettype none
module gplc_pin0_mux
	import gplc_pkg::*;
(
	input  wire logic [2:0]           src,
	input  wire logic [2:0]           sel,
	input  wire logic                 drive_value,
	input  wire logic [NUM_RX-1:0]    rx_enabled,
	input  wire gplc_rx_stat_t [3:0]  rx_stat,
	input  wire gplc_tx_stat_t [1:0]  tx_stat,
	input  wire logic                 frame_sync,
	output logic                      data
);
	gplc_rx_stat_t rx;
	gplc_tx_stat_t tx;
	logic          lock_or;
	logic          lock_and;
	logic          pass_and;

	// ----------------------------------------------------------------
	// combined status over enabled receive ports
	// ----------------------------------------------------------------
	always_comb begin
		lock_or  = 1'b0;
		lock_and = 1'b1;
		pass_and = 1'b1;
		for (int i = 0; i < NUM_RX; i++) begin
			if (rx_enabled[i]) begin
				lock_or  = lock_or | rx_stat[i].lock;
				lock_and = lock_and & rx_stat[i].lock;
				pass_and = pass_and & rx_stat[i].pass;
			end
		end
	end

	// source decode; reserved codes drive low
	always_comb begin
		rx   = rx_stat[src[1:0]];
		tx   = tx_stat[src[0]];
		data = 1'b0;
		if (!src[2]) begin
			case (sel)
				3'h0, 3'h1, 3'h2, 3'h3: data = rx.remote_pin[sel[1:0]];
				3'h4:    data = rx.lock;
				3'h5:    data = rx.pass;
				3'h6:    data = rx.frame_valid;
				default: data = rx.line_valid;
			endcase
		end else if (src == SRC_DEV) begin
			case (sel)
				3'h0:    data = drive_value;
				3'h1:    data = lock_or;
				3'h2:    data = lock_and;
				3'h3:    data = lock_and & pass_and;
				3'h4:    data = frame_sync;
				default: data = 1'b0;
			endcase
		end else if (src == SRC_TX0 || src == SRC_TX1) begin
			case (sel)
				3'h0:    data = tx.pass_and;
				3'h1:    data = tx.pass_or;
				3'h2:    data = tx.frame_valid;
				3'h3:    data = tx.line_valid;
				3'h4:    data = tx.synced;
				3'h5:    data = tx.irq;
				default: data = 1'b0;
			endcase
		end
	end
endmodule : gplc_pin0_mux
`default_nettype wire

// ### sim/gplc_pins_model.sv
// behavioural model of the board pins and supply sense around the block
`timescale 1ns/100ps
`default_nettype none
module gplc_pins_model (
	input  wire logic [7:0] pin_pat,
	input  wire logic       det,
	input  wire logic       pin0_out,
	input  wire logic       pin0_oe,
	output logic      [7:0] pin_in,
	output logic            detected_3v3
);
	// pin 0 shows the block's drive while enabled, else the board level
	assign pin_in       = {pin_pat[7:1], pin0_oe ? pin0_out : pin_pat[0]};
	// supply sense is a plain level from the board
	assign detected_3v3 = det;
endmodule : gplc_pins_model
`default_nettype wire

// ### sim/gplc_chk_sva.sv
// assertion checker for the pin and i/o level block
`timescale 1ns/100ps
`default_nettype none
module gplc_chk
	import gplc_pkg::*;
(
	input wire logic                hclk,
	input wire logic                hresetn,
	input wire logic                hsel,
	input wire logic [31:0]         haddr,
	input wire logic [1:0]          htrans,
	input wire logic                hwrite,
	input wire logic [31:0]         hwdata,
	input wire logic                hready,
	input wire logic [31:0]         hrdata,
	input wire logic                detected_3v3,
	input wire gplc_rx_stat_t [3:0] rx_stat,
	input wire gplc_tx_stat_t [1:0] tx_stat,
	input wire gplc_io_level_t      io_level,
	input wire logic [7:0]          pin_input_enable,
	input wire logic                pin0_out,
	input wire logic                pin0_oe
);
	logic       pend;
	logic [7:0] widx;
	logic [7:0] io_sh;
	logic [7:0] ien_sh;
	logic [7:0] p0_sh;
	logic       rd_io;
	// ------------------------------------------
	// write shadows, so checks need no view inside
	// ------------------------------------------
	assign rd_io = hsel && hready && htrans[1] && !hwrite && haddr[9:2] == IDX_IO_LEVEL_CONTROL;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend   <= 1'b0;
			widx   <= 8'h00;
			io_sh  <= 8'h00;
			ien_sh <= 8'hFF;
			p0_sh  <= 8'h00;
		end else if (hready) begin
			pend <= hsel && htrans[1] && hwrite;
			widx <= haddr[9:2];
			if (pend && widx == IDX_IO_LEVEL_CONTROL) io_sh <= hwdata[7:0];
			if (pend && widx == IDX_PIN_INPUT_ENABLES) ien_sh <= hwdata[7:0];
			if (pend && widx == IDX_PIN0_OUTPUT_CONTROL) p0_sh <= hwdata[7:0];
		end
	end
	// ------------------------------------------
	// properties
	// ------------------------------------------
	default clocking dc @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence p0_held;
		$stable(p0_sh) [*3];
	endsequence
	sequence rx_held;
		$stable(rx_stat) [*3];
	endsequence
	a_oe_from_reg: assert property (p0_held |-> pin0_oe == p0_sh[0])
		else $error("pin0 enable differs from its control bit");
	a_off_undriven: assert property (!pin0_oe |-> !pin0_out)
		else $error("pin0 data high while disabled");
	a_local_value: assert property ((p0_held ##0 p0_sh[7:2] == {3'h0, SRC_DEV})
		|-> pin0_out == (p0_sh[1] & p0_sh[0])) else $error("pin0 not the drive value");
	a_rx_route: assert property (((p0_held and rx_held) ##0 (!p0_sh[4] && !p0_sh[7] && p0_sh[0]))
		|-> pin0_out == rx_stat[p0_sh[3:2]].remote_pin[p0_sh[6:5]])
		else $error("pin0 not the chosen remote pin");
	a_tx_irq: assert property ((p0_held ##0 (p0_sh[7:3] == 5'b10111 && p0_sh[0]))
		|-> pin0_out == tx_stat[p0_sh[2]].irq) else $error("pin0 not the port interrupt");
	a_lvl_detect: assert property ((!io_sh[6] && $stable(detected_3v3)) [*4]
		|-> io_level == {3{detected_3v3}}) else $error("level not the detected one");
	a_lvl_written: assert property ((io_sh[6] && $stable(io_sh)) [*3]
		|-> io_level == {io_sh[7], io_sh[5:4]}) else $error("level not the written one");
	a_ien_copy: assert property ($stable(ien_sh) [*2] |-> pin_input_enable == ien_sh)
		else $error("input enables differ from register");
	a_rsv_zero: assert property ($past(rd_io) |-> hrdata[3:0] == 4'h0)
		else $error("reserved nibble not zero");
endmodule : gplc_chk
bind gplc_top gplc_chk chk (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .detected_3v3,
	.rx_stat, .tx_stat, .io_level, .pin_input_enable, .pin0_out, .pin0_oe
);
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the pin and i/o level block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import gplc_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hresp, det, detected_3v3, frame_sync;
	logic pin0_out, pin0_oe;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [7:0] pin_in, pin_pat, pin_input_enable;
	logic [7:0] ovr_w [4] = '{8'h4F, 8'hF0, 8'hC0, 8'h70};
	logic [3:0] rx_enabled;
	gplc_rx_stat_t [3:0] rx_stat;
	gplc_tx_stat_t [1:0] tx_stat;
	gplc_io_level_t io_level;
	int error_cnt, cmp_count, cyc;
	// 100 MHz clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	gplc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready, .hrdata, .hreadyout(hready), .hresp, .pin_in, .detected_3v3, .rx_enabled,
		.rx_stat, .tx_stat, .frame_sync, .io_level, .pin_input_enable, .pin0_out, .pin0_oe);
	gplc_pins_model pins (.pin_pat, .det, .pin0_out, .pin0_oe, .pin_in, .detected_3v3);
	// ------------------------------------------
	// bus tasks and checks
	// ------------------------------------------
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	// hang guard, well past the few hundred cycles the tests need
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr  <= {22'h0, idx, 2'b00};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : xfer
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk(rd[7:0], exp);
		chk({7'h0, hresp}, 8'h00);
	endtask : rdchk
	// expected pin 0 level; the drive value is always written as 1
	function automatic logic exp_pin0(input logic [2:0] src, input logic [2:0] sel);
		logic [7:0] r;
		logic [5:0] t;
		logic orl, andl, andp;
		r = rx_stat[src[1:0]];
		t = tx_stat[src[0]];
		orl = 1'b0;
		andl = 1'b1;
		andp = 1'b1;
		for (int p = 0; p < 4; p++) begin
			orl  = orl | (rx_enabled[p] & rx_stat[p].lock);
			andl = andl & (~rx_enabled[p] | rx_stat[p].lock);
			andp = andp & (~rx_enabled[p] | rx_stat[p].pass);
		end
		if (!src[2]) return sel[2] ? r[7 - sel] : r[4 + sel];
		if (src == SRC_DEV) begin
			case (sel)
				3'h0: return 1'b1;
				3'h1: return orl;
				3'h2: return andl;
				3'h3: return andl & andp;
				3'h4: return frame_sync;
				default: return 1'b0;
			endcase
		end
		if (src[1] && sel < 6) return t[5 - sel];
		return 1'b0;
	endfunction : exp_pin0
	// ------------------------------------------
	// tests
	// ------------------------------------------
	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, det, error_cnt, cmp_count, cyc} = '0;
		pin_pat = 8'hA5;
		rx_enabled = 4'b0101;
		rx_stat = {8'hA1, 8'h3D, 8'hC6, 8'h5A};
		tx_stat = {6'h16, 6'h2D};
		frame_sync = 1'b1;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		rdchk(IDX_IO_LEVEL_CONTROL, 8'h00);
		rdchk(IDX_PIN_INPUT_ENABLES, 8'hFF);
		rdchk(IDX_PIN0_OUTPUT_CONTROL, 8'h00);
		rdchk(IDX_PIN_LEVEL_SNAPSHOT, 8'hA5);
		chk({6'h0, pin0_oe, pin0_out}, 8'h00);
		$display("test reset done");
		det <= 1'b1;
		repeat (5) @(posedge hclk);
		xfer(1'b1, IDX_IO_LEVEL_CONTROL, 8'h0F);
		rdchk(IDX_IO_LEVEL_CONTROL, 8'hB0);
		chk({5'h0, io_level}, 8'h07);
		foreach (ovr_w[i]) begin
			xfer(1'b1, IDX_IO_LEVEL_CONTROL, ovr_w[i]);
			@(posedge hclk);
			rdchk(IDX_IO_LEVEL_CONTROL, ovr_w[i] & 8'hF0);
			chk({5'h0, io_level}, {5'h0, ovr_w[i][7], ovr_w[i][5:4]});
		end
		xfer(1'b1, IDX_IO_LEVEL_CONTROL, 8'h00);
		repeat (2) @(posedge hclk);
		chk({5'h0, io_level}, 8'h07);
		$display("test levels done");
		xfer(1'b1, IDX_PIN_INPUT_ENABLES, 8'h0F);
		pin_pat <= 8'h5A;
		repeat (3) @(posedge hclk);
		rdchk(IDX_PIN_INPUT_ENABLES, 8'h0F);
		chk(pin_input_enable, 8'h0F);
		rdchk(IDX_PIN_LEVEL_SNAPSHOT, 8'h0A);
		xfer(1'b1, IDX_PIN_INPUT_ENABLES, 8'hFF);
		xfer(1'b1, 8'h20, 8'hFF);
		rdchk(8'h20, 8'h00);
		rdchk(IDX_PIN_LEVEL_SNAPSHOT, 8'h5A);
		$display("test pins done");
		for (int e = 0; e < 2; e++) begin
			rx_enabled <= e ? 4'b0011 : 4'b0101;
			for (int s = 0; s < 8; s++) begin
				for (int v = 0; v < 8; v++) begin
					xfer(1'b1, IDX_PIN0_OUTPUT_CONTROL, {v[2:0], s[2:0], 2'b11});
					repeat (2) @(posedge hclk);
					chk({7'h0, pin0_out}, {7'h0, exp_pin0(s[2:0], v[2:0])});
				end
			end
		end
		xfer(1'b1, IDX_PIN0_OUTPUT_CONTROL, 8'h11);
		repeat (2) @(posedge hclk);
		chk({6'h0, pin0_oe, pin0_out}, 8'h02);
		xfer(1'b1, IDX_PIN0_OUTPUT_CONTROL, 8'h12);
		repeat (2) @(posedge hclk);
		chk({6'h0, pin0_oe, pin0_out}, 8'h00);
		rdchk(IDX_PIN0_OUTPUT_CONTROL, 8'h12);
		$display("test pin0 done");
		// reset in mid-run must put the controls back to their reset state
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		rdchk(IDX_PIN0_OUTPUT_CONTROL, 8'h00);
		rdchk(IDX_PIN_INPUT_ENABLES, 8'hFF);
		chk({6'h0, pin0_oe, pin0_out}, 8'h00);
		chk({5'h0, io_level}, 8'h07);
		$display("test mid reset done");
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
